// *** src/reset_combiner_pkg.sv ***
/*
 * constants, field layouts and state types for the reset source combiner.
 * assumes a single 200 MHz clock and an axi4-lite register port of 32 bits.
 */
package reset_combiner_pkg;

	// register byte offsets
	localparam logic [3:0] CTRL_OFFSET   = 4'h0;
	localparam logic [3:0] STATUS_OFFSET = 4'h4;

	// control register bit positions
	localparam int CTRL_WDT_EN_BIT  = 0;
	localparam int CTRL_MCLK_EN_BIT = 1;
	localparam int CTRL_CMP_EN_BIT  = 2;
	localparam int CTRL_SW_EN_BIT   = 3;
	localparam int CTRL_SW_FORCE_BIT = 4;
	localparam int CTRL_WDT_LOCK_BIT = 5;

	// status register field positions
	localparam int STATUS_CAUSE_LSB  = 0;
	localparam int STATUS_POR_BIT    = 6;
	localparam int STATUS_LIVE_LSB   = 8;
	localparam int STATUS_STRAP_BIT  = 14;
	localparam int STATUS_RESET_BIT  = 15;

	// reset value of the four maskable enables {sw, cmp, mclk, wdt}
	localparam logic [3:0] ENABLE_RESET_VALUE = 4'hb;

	// cycles the pin input is ignored after the device drove the pin
	localparam logic [2:0] PIN_BLANK_CYCLES = 3'h6;

	// axi response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// cause vector index: {pin, sw, cmp, mclk, wdt, monitor}
	localparam int CAUSE_WIDTH = 6;

	// on-chip reset requests from logic on the same clock, active high
	typedef struct packed {
		logic watchdog;
		logic missing_clock;
		logic comparator;
	} chip_sources_s;

	// three-stage synchroniser with its filtered value
	typedef struct packed {
		logic [2:0] stage;
		logic       level;
	} pin_sync_s;

	// whole state of the combiner
	typedef struct packed {
		pin_sync_s               pin;
		pin_sync_s               strap;
		pin_sync_s               monitor;
		logic [2:0]              blank;
		logic [3:0]              enable;
		logic                    wdt_lock;
		logic                    sw_force;
		logic [CAUSE_WIDTH-1:0]  cause;
		logic                    por;
		logic                    sys_reset;
		logic                    aw_have;
		logic [3:0]              awaddr;
		logic                    w_have;
		logic [31:0]             wdata;
		logic                    wstrb0;
		logic                    bvalid;
		logic [1:0]              bresp;
		logic                    rvalid;
		logic [31:0]             rdata;
		logic [1:0]              rresp;
	} state_s;

endpackage : reset_combiner_pkg

// *** src/reset_source_combiner.sv ***
/*
 * reset source combiner: merges supply monitor, watchdog, missing clock,
 * comparator level, software force and the external pin into one reset,
 * and drives that reset back out on the open-drain pin.
 * assumes aresetn is the power-on reset and that pins are asynchronous.
 */
`timescale 1ns/100ps
`default_nettype none

// How it works
// R01: six sources feed the internal reset
// R02: external pin low resets the device
// R03: internal reset drives the pin low
// R04: supply monitor counts only with strap high
// R05: software masks all but monitor and pin
// R06: watchdog lock prevents later watchdog disable
// R07: reset is OR of enabled sources
module reset_source_combiner
	import reset_combiner_pkg::*;
(
	// clock and power-on reset
	input  wire logic          aclk,
	input  wire logic          aresetn,
	// axi4-lite write address
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_awaddr,
	input  wire logic [2:0]    s_axi_awprot,
	// axi4-lite write data
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	// axi4-lite write response
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	output logic [1:0]         s_axi_bresp,
	// axi4-lite read address
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	input  wire logic [31:0]   s_axi_araddr,
	input  wire logic [2:0]    s_axi_arprot,
	// axi4-lite read data
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	// reset sources
	input  wire chip_sources_s chip_sources,
	input  wire logic          supply_monitor_trip,
	input  wire logic          supply_monitor_enable_strap,
	// bidirectional open-drain reset pin, low means reset
	input  wire logic          ext_reset_n_in,
	output logic               ext_reset_n_out,
	output logic               ext_reset_n_oe,
	// combined reset to the rest of the chip
	output logic               sys_reset
);

	state_s                 st;          // registered state
	state_s                 next_st;     // next state
	logic [CAUSE_WIDTH-1:0] active;      // sources asserting right now
	logic [CAUSE_WIDTH-1:0] gated;       // sources allowed through
	logic                   wr_fire;     // write performed this cycle
	logic                   ar_fire;     // read address taken this cycle
	logic [31:0]            ctrl_view;   // control register read value
	logic [31:0]            status_view; // status register read value

	// synchroniser step: first stage feeds only the second, level moves
	// once the second and third stages agree
	function automatic pin_sync_s sync_step(input pin_sync_s s, input logic d);
		pin_sync_s r;
		r = s;
		r.stage = {s.stage[1:0], d};
		if (s.stage[1] == s.stage[2]) begin
			r.level = s.stage[2];
		end
		return r;
	endfunction : sync_step

	// raw source vector {pin, sw, cmp, mclk, wdt, monitor}
	always_comb begin
		active[0] = st.monitor.level & st.strap.level; // R04
		active[1] = chip_sources.watchdog;
		active[2] = chip_sources.missing_clock;
		active[3] = chip_sources.comparator;
		active[4] = st.sw_force;
		// our own drive reads back low, so the pin is blanked meanwhile
		active[5] = ~st.pin.level & ~st.sys_reset & (st.blank == '0); // R02
	end

	// masking: monitor and pin always pass, the rest per enable bit
	always_comb begin
		gated    = active;                                            // R01
		gated[1] = active[1] & (st.enable[CTRL_WDT_EN_BIT] | st.wdt_lock); // R05 R06
		gated[2] = active[2] & st.enable[CTRL_MCLK_EN_BIT];           // R05
		gated[3] = active[3] & st.enable[CTRL_CMP_EN_BIT];            // R05
		gated[4] = active[4] & st.enable[CTRL_SW_EN_BIT];             // R05
	end

	// register read views
	always_comb begin
		ctrl_view = '0;
		ctrl_view[CTRL_SW_EN_BIT:CTRL_WDT_EN_BIT] = st.enable;
		ctrl_view[CTRL_WDT_LOCK_BIT] = st.wdt_lock;
		status_view = '0;
		status_view[STATUS_CAUSE_LSB +: CAUSE_WIDTH] = st.cause;
		status_view[STATUS_POR_BIT] = st.por;
		status_view[STATUS_LIVE_LSB +: CAUSE_WIDTH] = active;
		status_view[STATUS_STRAP_BIT] = st.strap.level;
		status_view[STATUS_RESET_BIT] = st.sys_reset;
	end

	// handshakes: one write and one read held at a time
	assign s_axi_awready = ~st.aw_have & ~st.bvalid;
	assign s_axi_wready  = ~st.w_have & ~st.bvalid;
	assign s_axi_arready = ~st.rvalid;
	assign wr_fire       = st.aw_have & st.w_have & ~st.bvalid;
	assign ar_fire       = s_axi_arvalid & ~st.rvalid;

	// next-state logic
	always_comb begin
		next_st = st;

		// pin inputs through three flip-flops
		next_st.pin     = sync_step(st.pin, ext_reset_n_in);
		next_st.strap   = sync_step(st.strap, supply_monitor_enable_strap);
		next_st.monitor = sync_step(st.monitor, supply_monitor_trip);

		// software force is a single-cycle request
		next_st.sw_force = 1'b0;

		// combined reset, registered to keep the pin drive glitch free
		next_st.sys_reset = |gated; // R07

		// blanking window restarts whenever we drive the pin
		if (st.sys_reset) begin
			next_st.blank = PIN_BLANK_CYCLES; // R03
		end else if (st.blank != '0) begin
			next_st.blank = st.blank - 3'h1;
		end

		// cause capture: fresh on a new reset, accumulating while in it
		if (|gated) begin
			if (!st.sys_reset) begin
				next_st.cause = gated;
				next_st.por   = 1'b0;
			end else begin
				next_st.cause = st.cause | gated;
			end
		end

		// an internal reset restores the enables; the lock survives it
		if (st.sys_reset) begin
			next_st.enable = ENABLE_RESET_VALUE;
		end

		// write address and data captured in either order
		if (s_axi_awvalid && s_axi_awready) begin
			next_st.aw_have = 1'b1;
			next_st.awaddr  = s_axi_awaddr[3:0];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_st.w_have = 1'b1;
			next_st.wdata  = s_axi_wdata;
			next_st.wstrb0 = s_axi_wstrb[0];
		end

		// write performed once both halves are here
		if (wr_fire) begin
			next_st.aw_have = 1'b0;
			next_st.w_have  = 1'b0;
			next_st.bvalid  = 1'b1;
			next_st.bresp   = RESP_OKAY;
			if (st.awaddr == CTRL_OFFSET) begin
				if (st.wstrb0) begin
					next_st.enable = st.wdata[CTRL_SW_EN_BIT:CTRL_WDT_EN_BIT]; // R05
					next_st.sw_force = st.wdata[CTRL_SW_FORCE_BIT];
					// lock is set-only; power-on reset alone clears it
					if (st.wdata[CTRL_WDT_LOCK_BIT]) begin
						next_st.wdt_lock = 1'b1; // R06
					end
				end
			end else if (st.awaddr != STATUS_OFFSET) begin
				next_st.bresp = RESP_SLVERR; // unmapped
			end
		end else if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end

		// a locked watchdog enable always reads and acts as set
		if (next_st.wdt_lock) begin
			next_st.enable[CTRL_WDT_EN_BIT] = 1'b1; // R06
		end

		// read: data registered one cycle after the address is taken
		if (ar_fire) begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = RESP_OKAY;
			unique case (s_axi_araddr[3:0])
				CTRL_OFFSET: begin
					next_st.rdata = ctrl_view;
				end
				STATUS_OFFSET: begin
					next_st.rdata = status_view;
				end
				default: begin
					next_st.rdata = '0;
					next_st.rresp = RESP_SLVERR;
				end
			endcase
		end else if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
	end

	// state register; aresetn is the power-on reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st           <= '0;
			st.pin.stage <= '1;    // pin idles high
			st.pin.level <= 1'b1;
			st.enable    <= ENABLE_RESET_VALUE;
			st.por       <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// outputs
	assign s_axi_bvalid    = st.bvalid;
	assign s_axi_bresp     = st.bresp;
	assign s_axi_rvalid    = st.rvalid;
	assign s_axi_rdata     = st.rdata;
	assign s_axi_rresp     = st.rresp;
	assign sys_reset       = st.sys_reset;
	assign ext_reset_n_out = 1'b0;          // open drain: only ever pulls low
	assign ext_reset_n_oe  = st.sys_reset;  // R03

endmodule : reset_source_combiner

`default_nettype wire

// *** testbench/reset_combiner_properties.sv ***
/* port checker for the reset source combiner.
   assumes it is bound into every reset_source_combiner instance. */
`timescale 1ns/100ps
`default_nettype none
module reset_combiner_properties
	import reset_combiner_pkg::*;
(
	// clock and power-on reset
	input wire logic          aclk,
	input wire logic          aresetn,
	// reset sources and pin
	input wire chip_sources_s chip_sources,
	input wire logic          supply_monitor_trip,
	input wire logic          supply_monitor_enable_strap,
	input wire logic          ext_reset_n_in,
	input wire logic          ext_reset_n_out,
	input wire logic          ext_reset_n_oe,
	// write response and combined reset
	input wire logic          s_axi_bvalid,
	input wire logic          sys_reset
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic       any_src; // anything that may start a reset
	logic [5:0] hist;    // recent history of any_src
	assign any_src = |chip_sources || supply_monitor_trip || !ext_reset_n_in || s_axi_bvalid;
	// history covers the synchroniser delay of the pin and monitor
	always_ff @(posedge aclk) begin
		hist <= {hist[4:0], any_src};
	end
	AST_PIN_DRIVE: assert property (ext_reset_n_oe == sys_reset && !ext_reset_n_out)
		else $error("pin drive differs from internal reset");
	// a held pin retriggers seven cycles after each pulse, once blanking ends
	AST_PIN_IN: assert property ((!ext_reset_n_in && !sys_reset) [*7] |-> ##[1:6] sys_reset)
		else $error("held pin low did not reset");
	AST_MONITOR: assert property (
		(supply_monitor_trip && supply_monitor_enable_strap) [*6] |-> ##[0:2] sys_reset)
		else $error("monitor trip with strap high did not reset");
	// the monitor is never blanked, so a held trip keeps the reset up
	AST_MONITOR_HOLD: assert property (
		(supply_monitor_trip && supply_monitor_enable_strap) [*8] |-> sys_reset)
		else $error("monitor reset dropped while trip held");
	AST_QUIET: assert property ((!any_src) [*6] |=> !sys_reset)
		else $error("reset without any source");
	AST_CAUSE: assert property ($rose(sys_reset) |-> hist != 6'h00)
		else $error("reset rose with no recent source");
endmodule : reset_combiner_properties
bind reset_source_combiner reset_combiner_properties u_props (
	.aclk(aclk), .aresetn(aresetn), .chip_sources(chip_sources),
	.supply_monitor_trip(supply_monitor_trip),
	.supply_monitor_enable_strap(supply_monitor_enable_strap),
	.ext_reset_n_in(ext_reset_n_in), .ext_reset_n_out(ext_reset_n_out),
	.ext_reset_n_oe(ext_reset_n_oe), .s_axi_bvalid(s_axi_bvalid), .sys_reset(sys_reset));
`default_nettype wire

// *** testbench/reset_board_model.sv ***
/* board model: pulled-up open-drain reset wire, push button and monitor strap.
   assumes the combiner only ever pulls the wire low. */
`timescale 1ns/100ps
`default_nettype none
module reset_board_model (
	// combiner pin side
	input  wire logic pin_out,
	input  wire logic pin_oe,
	output logic      pin_level,
	// bench controls
	input  wire logic button,
	input  wire logic strap_high,
	output logic      strap
);
	// wired-and with pull-up, so a released wire reads high
	assign pin_level = !(button || (pin_oe && !pin_out));
	// strap is simply tied on boards that use the monitor
	assign strap = strap_high;
endmodule : reset_board_model
`default_nettype wire

// *** testbench/reset_source_combiner_tb_top.sv ***
/* bench for the reset source combiner: axi4-lite tasks and source scenarios.
   assumes the board model closes the reset wire. */
`timescale 1ns/100ps
`default_nettype none
module reset_source_combiner_tb_top
	import reset_combiner_pkg::*;
;
	// bus, sources and results
	logic          aclk, aresetn = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic          s_axi_arready, s_axi_rvalid, sys_reset, ext_reset_n_in;
	logic          s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic          s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, button = 1'h0;
	logic          supply_monitor_trip = 1'h0, strap_high = 1'h1;
	logic          supply_monitor_enable_strap, ext_reset_n_out, ext_reset_n_oe;
	logic [2:0]    s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [3:0]    s_axi_wstrb = 4'hf;
	logic [31:0]   s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
	logic [31:0]   s_axi_rdata, rd;
	logic [1:0]    s_axi_bresp, s_axi_rresp, rsp;
	chip_sources_s chip_sources = 3'h0;
	int            errors = 0, total_checks = 0, hi;
	reset_source_combiner DUT (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.chip_sources(chip_sources), .supply_monitor_trip(supply_monitor_trip),
		.supply_monitor_enable_strap(supply_monitor_enable_strap),
		.ext_reset_n_in(ext_reset_n_in), .ext_reset_n_out(ext_reset_n_out),
		.ext_reset_n_oe(ext_reset_n_oe), .sys_reset(sys_reset));
	reset_board_model board (.pin_out(ext_reset_n_out), .pin_oe(ext_reset_n_oe),
		.pin_level(ext_reset_n_in), .button(button), .strap_high(strap_high),
		.strap(supply_monitor_enable_strap));
	initial begin
		aclk = 1'h0;
		forever #2.5 aclk = !aclk;
	end
	task automatic check(input string what, input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [31:0] a, d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
		rsp = s_axi_bresp;
	endtask : wr
	task automatic rd_reg(input logic [31:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		s_axi_rready <= 1'h0;
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
	endtask : rd_reg
	// counts cycles of internal reset over a window
	task automatic watch(input int n);
		hi = 0;
		repeat (n) begin
			@(posedge aclk);
			// an unknown counts as reset, so masked checks catch it
			hi += int'(sys_reset !== 1'h0);
		end
	endtask : watch
	task automatic wrap_up;
		if (errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up
	initial begin
		#20us;
		errors++;
		wrap_up();
	end
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		rd_reg(32'h0);
		check("ctrl reset", rd, 32'h0000000b);
		rd_reg(32'h4);
		check("status por", {rd[15], rd[6]}, 32'h1);
		rd_reg(32'h8);
		check("unmapped resp", rsp, 32'h2);
		wr(32'h8, 32'h0);
		check("unmapped write resp", rsp, 32'h2);
		chip_sources.watchdog <= 1'h1;
		watch(8);
		check("watchdog reset", hi > 0, 32'h1);
		check("pin driven", ext_reset_n_in, 32'h0);
		chip_sources.watchdog <= 1'h0;
		watch(20);
		// cause holds the watchdog alone, strap synced high, no power-on flag
		rd_reg(32'h4);
		check("status cause", rd, 32'h00004002);
		wr(32'h0, 32'h0);
		check("write resp", rsp, 32'h0);
		chip_sources <= 3'h6;
		watch(10);
		check("masked sources", hi, 32'h0);
		chip_sources <= 3'h0;
		wr(32'h0, 32'h4);
		chip_sources.comparator <= 1'h1;
		watch(8);
		check("comparator reset", hi > 0, 32'h1);
		chip_sources.comparator <= 1'h0;
		watch(20);
		// the internal reset above restored the missing clock enable
		chip_sources.missing_clock <= 1'h1;
		watch(8);
		check("missing clock reset", hi > 0, 32'h1);
		chip_sources.missing_clock <= 1'h0;
		watch(20);
		wr(32'h0, 32'h20);
		wr(32'h0, 32'h0);
		rd_reg(32'h0);
		check("lock keeps watchdog", rd[0], 32'h1);
		chip_sources.watchdog <= 1'h1;
		watch(8);
		check("locked watchdog reset", hi > 0, 32'h1);
		chip_sources.watchdog <= 1'h0;
		watch(20);
		wr(32'h0, 32'h18);
		watch(10);
		check("software pulse", hi, 32'h1);
		wr(32'h0, 32'h11);
		watch(10);
		check("software masked", hi, 32'h0);
		button <= 1'h1;
		// held past one blanking span so the pin retriggers the reset
		watch(16);
		check("pin reset", hi > 0, 32'h1);
		button <= 1'h0;
		watch(20);
		strap_high <= 1'h0;
		supply_monitor_trip <= 1'h1;
		watch(12);
		check("monitor strap low", hi, 32'h0);
		strap_high <= 1'h1;
		watch(12);
		check("monitor reset", hi > 0, 32'h1);
		supply_monitor_trip <= 1'h0;
		watch(20);
		wrap_up();
	end
endmodule : reset_source_combiner_tb_top
`default_nettype wire
